// ### src/dtc_pkg.sv
package dtc_pkg;

  // Core geometry
  localparam int unsigned DTC_THREADS = 2;
  localparam int unsigned DTC_XLEN = 64;
  localparam int unsigned DTC_CTRL_W = 32;

  // Bits are numbered from the most significant end; these are vector indices
  localparam int unsigned DTC_IMPL_SERIAL = 63 - 3;
  localparam int unsigned DTC_IMPL_THERM_WAKE = 63 - 22;
  localparam int unsigned DTC_IMPL_SYSERR_WAKE = 63 - 24;
  localparam int unsigned DTC_IMPL_PREC_MCHK = 63 - 26;
  localparam int unsigned DTC_IMPL_THERM_MASTER = 63 - 29;
  localparam int unsigned DTC_IMPL_EXT_FAULT = 63 - 30;

  localparam int unsigned DTC_PART_LIMIT_HI = 63 - 34;
  localparam int unsigned DTC_PART_LIMIT_LO = 63 - 37;
  localparam int unsigned DTC_PART_EXT_REQ = 63 - 52;
  localparam int unsigned DTC_PART_TLB = 63 - 53;
  localparam int unsigned DTC_PART_ENV_HI = 63 - 60;
  localparam int unsigned DTC_PART_ENV_LO = 63 - 61;
  localparam int unsigned DTC_PART_UNCACHED = 63 - 62;
  localparam int unsigned DTC_PART_HDEC_IRQ = 63 - 63;

  localparam int unsigned DTC_CTRL_CT0 = 31 - 0;
  localparam int unsigned DTC_CTRL_CT1 = 31 - 1;
  localparam int unsigned DTC_CTRL_TE0 = 31 - 8;
  localparam int unsigned DTC_CTRL_TE1 = 31 - 9;
  localparam int unsigned DTC_CTRL_TH0 = 31 - 16;
  localparam int unsigned DTC_CTRL_TH1 = 31 - 17;
  localparam int unsigned DTC_CTRL_RUN = 31 - 31;

  // Reset values
  localparam logic [1:0] DTC_RUN_EN_RESET = 2'h1;
  localparam logic DTC_RUN_RESET = 1'h0;
  localparam logic [3:0] DTC_REAL_MODE_LIMIT_SELECT_RESET = 4'h0;
  localparam logic [1:0] DTC_ENV_RESET = 2'h0;

  typedef enum logic [1:0] {
    DTC_SEL_IMPL,
    DTC_SEL_PART,
    DTC_SEL_CTRL,
    DTC_SEL_NONE
  } dtc_sel_e;

  typedef struct packed {
    logic wr;
    logic rd;
    dtc_sel_e sel;
    logic thread;
    logic [63:0] wdata;
  } dtc_spr_req_s;

  typedef struct packed {
    logic hypervisor_bit;
    logic problem_bit;
  } dtc_priv_s;

  typedef struct packed {
    logic mediated_ext_request;
    logic real_mode_uncached;
    logic hyper_countdown_irq_ctl;
  } dtc_dup_s;

endpackage

// ### src/dtc_thread_slot.sv
`timescale 1ns/1ps
module dtc_thread_slot
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Duplicated partition bits
  input wire logic dup_wr,
  input wire dtc_dup_s dup_wdata,
  output dtc_dup_s dup_q,
  // Caching-inhibited load tracking
  input wire logic prec_en,
  input wire logic ci_load_issue,
  input wire logic ci_load_done,
  output logic flush_younger,
  output logic dispatch_block
);

  typedef enum logic {DTC_FLOW, DTC_WAIT_LOAD} dtc_slot_e;

  dtc_slot_e state;
  dtc_slot_e next_state;
  dtc_dup_s next_dup_q;
  logic next_flush_younger;
  logic next_dispatch_block;

  always_comb begin
    next_dup_q = dup_q;
    next_state = state;
    next_flush_younger = 1'b0;
    if (dup_wr) begin
      next_dup_q = dup_wdata;
    end
    case (state)
      DTC_FLOW: begin
        if (prec_en && ci_load_issue) begin
          next_state = DTC_WAIT_LOAD;
          next_flush_younger = 1'b1;
        end
      end
      DTC_WAIT_LOAD: begin
        if (ci_load_done) begin
          next_state = DTC_FLOW;
        end
      end
      default: next_state = DTC_FLOW;
    endcase
    next_dispatch_block = (next_state == DTC_WAIT_LOAD);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= DTC_FLOW;
      dup_q <= '0;
      flush_younger <= 1'b0;
      dispatch_block <= 1'b0;
    end else begin
      state <= next_state;
      dup_q <= next_dup_q;
      flush_younger <= next_flush_younger;
      dispatch_block <= next_dispatch_block;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  load_block_a: assert property ($rose(dispatch_block) |->
    $past(prec_en && ci_load_issue) && flush_younger)
    else $error("dispatch block rose without a guarded load");
  block_release_a: assert property (dispatch_block && ci_load_done |=>
    !dispatch_block || $past(prec_en && ci_load_issue))
    else $error("dispatch block held after load data");

endmodule

// ### src/dtc_regs.sv
`timescale 1ns/1ps
module dtc_regs
  import dtc_pkg::*;
#(
  parameter logic [1:0] RUN_EN_RESET = DTC_RUN_EN_RESET
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Special-register move port, same clock as the core
  input wire dtc_spr_req_s spr_req,
  input wire dtc_priv_s [1:0] thread_priv,
  output logic [63:0] spr_rdata,
  output logic spr_rd_valid,
  // Interrupt events from core logic
  input wire logic therm_event,
  input wire logic syserr_event,
  input wire logic [1:0] syserr_target,
  output logic therm_irq_take,
  output logic [1:0] syserr_irq_take,
  // Thread state
  output logic [1:0] thread_enable,
  // Issue and dispatch control
  output logic one_at_a_time_issue,
  output logic dual_issue_en,
  input wire logic [1:0] ci_load_issue,
  input wire logic [1:0] ci_load_done,
  output logic [1:0] flush_younger,
  output logic [1:0] dispatch_block,
  // Partition controls
  output logic [3:0] real_mode_limit_select,
  output logic tlb_fill_source,
  output logic [1:0] partition_env_select,
  output dtc_dup_s [1:0] part_dup
);

  if (RUN_EN_RESET == 2'h0) begin : g_run_en_check
    $error("dtc_regs: at least one thread must run out of reset");
  end

  // Implementation config fields
  logic serial;
  logic heat_alarm_rouse;
  logic fault_rouse;
  logic exact_machine_fault;
  logic heat_alarm_master_on;
  logic outside_fault_on;
  logic next_serial;
  logic next_heat_alarm_rouse;
  logic next_fault_rouse;
  logic next_exact_machine_fault;
  logic next_heat_alarm_master_on;
  logic next_outside_fault_on;

  // Shared partition fields
  logic [3:0] next_limit;
  logic next_tlb;
  logic [1:0] next_env;

  // Thread control fields
  logic [1:0] next_run_en;
  logic run_bit;
  logic next_run_bit;
  logic [1:0] write_hist;
  logic [1:0] next_write_hist;
  logic [1:0] wake;
  logic [1:0] run_en_wdata;
  logic priv_ok;

  // Read path and events
  logic [63:0] next_rdata;
  logic next_rd_valid;
  logic next_therm_take;
  logic [1:0] next_syserr_take;
  logic [31:0] ctrl_word;

  logic impl_wr;
  logic part_wr;
  logic ctrl_wr;

  assign impl_wr = spr_req.wr && (spr_req.sel == DTC_SEL_IMPL);
  assign part_wr = spr_req.wr && (spr_req.sel == DTC_SEL_PART);
  assign ctrl_wr = spr_req.wr && (spr_req.sel == DTC_SEL_CTRL);

  // Per-thread duplicated partition bits and load blocking
  for (genvar t = 0; t < DTC_THREADS; t++) begin : g_slot
    dtc_thread_slot u_slot (
      .clk(clk),
      .reset(reset),
      .dup_wr(part_wr && (spr_req.thread == 1'(t))),
      .dup_wdata(dtc_dup_s'{mediated_ext_request: spr_req.wdata[DTC_PART_EXT_REQ],
        real_mode_uncached: spr_req.wdata[DTC_PART_UNCACHED],
        hyper_countdown_irq_ctl: spr_req.wdata[DTC_PART_HDEC_IRQ]}),
      .dup_q(part_dup[t]),
      .prec_en(exact_machine_fault),
      .ci_load_issue(ci_load_issue[t]),
      .ci_load_done(ci_load_done[t]),
      .flush_younger(flush_younger[t]),
      .dispatch_block(dispatch_block[t])
    );
  end

  // Config registers and interrupt gating
  always_comb begin
    next_serial = serial;
    next_heat_alarm_rouse = heat_alarm_rouse;
    next_fault_rouse = fault_rouse;
    next_exact_machine_fault = exact_machine_fault;
    next_heat_alarm_master_on = heat_alarm_master_on;
    next_outside_fault_on = outside_fault_on;
    next_limit = real_mode_limit_select;
    next_tlb = tlb_fill_source;
    next_env = partition_env_select;
    if (impl_wr) begin
      next_serial = spr_req.wdata[DTC_IMPL_SERIAL];
      next_heat_alarm_rouse = spr_req.wdata[DTC_IMPL_THERM_WAKE];
      next_fault_rouse = spr_req.wdata[DTC_IMPL_SYSERR_WAKE];
      next_exact_machine_fault = spr_req.wdata[DTC_IMPL_PREC_MCHK];
      next_heat_alarm_master_on = spr_req.wdata[DTC_IMPL_THERM_MASTER];
      next_outside_fault_on = spr_req.wdata[DTC_IMPL_EXT_FAULT];
    end
    if (part_wr) begin
      // Either thread writes the one shared copy
      next_limit = spr_req.wdata[DTC_PART_LIMIT_HI:DTC_PART_LIMIT_LO];
      next_tlb = spr_req.wdata[DTC_PART_TLB];
      next_env = spr_req.wdata[DTC_PART_ENV_HI:DTC_PART_ENV_LO];
    end
    next_therm_take = therm_event && heat_alarm_master_on;
    next_syserr_take = syserr_target & {2{syserr_event && outside_fault_on}};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      serial <= 1'b0;
      heat_alarm_rouse <= 1'b0;
      fault_rouse <= 1'b0;
      exact_machine_fault <= 1'b0;
      heat_alarm_master_on <= 1'b0;
      outside_fault_on <= 1'b0;
      one_at_a_time_issue <= 1'b0;
      dual_issue_en <= 1'b1;
      real_mode_limit_select <= DTC_REAL_MODE_LIMIT_SELECT_RESET;
      tlb_fill_source <= 1'b0;
      partition_env_select <= DTC_ENV_RESET;
      therm_irq_take <= 1'b0;
      syserr_irq_take <= 2'h0;
    end else begin
      serial <= next_serial;
      heat_alarm_rouse <= next_heat_alarm_rouse;
      fault_rouse <= next_fault_rouse;
      exact_machine_fault <= next_exact_machine_fault;
      heat_alarm_master_on <= next_heat_alarm_master_on;
      outside_fault_on <= next_outside_fault_on;
      one_at_a_time_issue <= next_serial;
      dual_issue_en <= !next_serial;
      real_mode_limit_select <= next_limit;
      tlb_fill_source <= next_tlb;
      partition_env_select <= next_env;
      therm_irq_take <= next_therm_take;
      syserr_irq_take <= next_syserr_take;
    end
  end

  // Thread control: enables, run bit and writer history
  always_comb begin
    next_run_en = thread_enable;
    next_run_bit = run_bit;
    next_write_hist = write_hist;
    run_en_wdata = {spr_req.wdata[DTC_CTRL_TE1], spr_req.wdata[DTC_CTRL_TE0]};
    priv_ok = thread_priv[spr_req.thread].hypervisor_bit
      && !thread_priv[spr_req.thread].problem_bit;
    // Wakeups ignore the interrupt enables, so a masked source can still rouse a thread
    wake = ({2{therm_event && heat_alarm_rouse}}
      | (syserr_target & {2{syserr_event && fault_rouse}}))
      & ~thread_enable;
    if (ctrl_wr) begin
      next_run_bit = spr_req.wdata[DTC_CTRL_RUN];
      // Written history bits are dropped; only the writer's identity lands here
      next_write_hist = spr_req.thread ? 2'h2 : 2'h1;
      if (priv_ok) begin
        if (!run_en_wdata[spr_req.thread]) begin
          next_run_en[spr_req.thread] = 1'b0;
        end
        if (run_en_wdata[!spr_req.thread]) begin
          next_run_en[!spr_req.thread] = 1'b1;
        end
      end
    end
    // A self-suspend in the same cycle as a wakeup wins; wake only covers threads already suspended
    next_run_en = next_run_en | wake;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      thread_enable <= RUN_EN_RESET;
      run_bit <= DTC_RUN_RESET;
      write_hist <= 2'h0;
    end else begin
      thread_enable <= next_run_en;
      run_bit <= next_run_bit;
      write_hist <= next_write_hist;
    end
  end

  // Read path, one cycle behind the request
  always_comb begin
    ctrl_word = '0;
    ctrl_word[DTC_CTRL_CT0] = !spr_req.thread;
    ctrl_word[DTC_CTRL_CT1] = spr_req.thread;
    ctrl_word[DTC_CTRL_TE0] = thread_enable[0];
    ctrl_word[DTC_CTRL_TE1] = thread_enable[1];
    ctrl_word[DTC_CTRL_TH0] = write_hist[0];
    ctrl_word[DTC_CTRL_TH1] = write_hist[1];
    ctrl_word[DTC_CTRL_RUN] = run_bit;
    next_rdata = '0;
    case (spr_req.sel)
      DTC_SEL_IMPL: begin
        next_rdata[DTC_IMPL_SERIAL] = serial;
        next_rdata[DTC_IMPL_THERM_WAKE] = heat_alarm_rouse;
        next_rdata[DTC_IMPL_SYSERR_WAKE] = fault_rouse;
        next_rdata[DTC_IMPL_PREC_MCHK] = exact_machine_fault;
        next_rdata[DTC_IMPL_THERM_MASTER] = heat_alarm_master_on;
        next_rdata[DTC_IMPL_EXT_FAULT] = outside_fault_on;
      end
      DTC_SEL_PART: begin
        next_rdata[DTC_PART_LIMIT_HI:DTC_PART_LIMIT_LO] = real_mode_limit_select;
        next_rdata[DTC_PART_TLB] = tlb_fill_source;
        next_rdata[DTC_PART_ENV_HI:DTC_PART_ENV_LO] = partition_env_select;
        next_rdata[DTC_PART_EXT_REQ] = part_dup[spr_req.thread].mediated_ext_request;
        next_rdata[DTC_PART_UNCACHED] = part_dup[spr_req.thread].real_mode_uncached;
        next_rdata[DTC_PART_HDEC_IRQ] = part_dup[spr_req.thread].hyper_countdown_irq_ctl;
      end
      DTC_SEL_CTRL: next_rdata[31:0] = ctrl_word;
      default: next_rdata = '0;
    endcase
    next_rd_valid = spr_req.rd;
    if (!spr_req.rd) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      spr_rdata <= '0;
      spr_rd_valid <= 1'b0;
    end else begin
      spr_rdata <= next_rdata;
      spr_rd_valid <= next_rd_valid;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  serial_mode_a: assert property (impl_wr |=>
    one_at_a_time_issue == $past(spr_req.wdata[DTC_IMPL_SERIAL])
    && dual_issue_en != one_at_a_time_issue)
    else $error("issue serialise output does not follow the written bit");
  therm_wake_a: assert property (therm_event && heat_alarm_rouse |=> &thread_enable)
    else $error("thermal wakeup left a thread suspended");
  fault_wake_a: assert property (syserr_event && fault_rouse |=>
    (thread_enable & $past(syserr_target)) == $past(syserr_target))
    else $error("system error wakeup missed a targeted thread");
  fault_mask_a: assert property (syserr_event && fault_rouse && !outside_fault_on &&
    syserr_target[0] |=> thread_enable[0] && !syserr_irq_take[0])
    else $error("masked system error wrongly taken or wake lost");
  therm_gate_a: assert property (therm_irq_take |->
    $past(therm_event && heat_alarm_master_on))
    else $error("thermal interrupt taken while suppressed");
  ext_fault_a: assert property (syserr_event && outside_fault_on && syserr_target[1] |=>
    syserr_irq_take[1])
    else $error("enabled system error not taken");
  self_suspend_a: assert property ($fell(thread_enable[1]) |->
    $past(ctrl_wr && spr_req.thread && priv_ok))
    else $error("thread suspended by other thread or without privilege");
  run_en_priv_a: assert property (ctrl_wr && !priv_ok && wake == 2'h0 |=>
    $stable(thread_enable))
    else $error("run enables changed outside hypervisor state");
  hist_write_a: assert property (ctrl_wr |=>
    write_hist == ($past(spr_req.thread) ? 2'h2 : 2'h1))
    else $error("history bits do not name the writer");
  thread_id_a: assert property (spr_req.rd && spr_req.sel == DTC_SEL_CTRL |=>
    spr_rd_valid && $onehot(spr_rdata[DTC_CTRL_CT0:DTC_CTRL_CT1])
    && spr_rdata[DTC_CTRL_CT1] == $past(spr_req.thread))
    else $error("current thread id wrong on read");
  dup_keep_a: assert property (part_wr && spr_req.thread |=> $stable(part_dup[0]))
    else $error("thread 1 write disturbed thread 0 partition copy");
  shared_part_a: assert property (part_wr |=>
    tlb_fill_source == $past(spr_req.wdata[DTC_PART_TLB]))
    else $error("shared partition field not updated");

endmodule

// ### test/dtc_regs_test.sv
`timescale 1ns/1ps
module dtc_regs_test
  import dtc_pkg::*;
();
  logic clk;
  logic reset;
  dtc_spr_req_s req;
  dtc_priv_s [1:0] priv;
  logic therm_ev;
  logic sys_ev;
  logic [1:0] sys_tgt;
  logic [1:0] ci_iss;
  logic [1:0] ci_done;
  logic [63:0] rdata;
  logic rvalid;
  logic therm_take;
  logic [1:0] sys_take;
  logic [1:0] ten;
  logic serial;
  logic dual;
  logic [1:0] flush;
  logic [1:0] blk;
  logic [3:0] limit_sel;
  logic tlb;
  logic [1:0] env;
  dtc_dup_s [1:0] dup;
  int n_mismatch;
  int cmp_count;
  int cycles;
  logic [63:0] q;

  dtc_regs u_dut (
    .clk(clk), .reset(reset), .spr_req(req), .thread_priv(priv),
    .spr_rdata(rdata), .spr_rd_valid(rvalid), .therm_event(therm_ev),
    .syserr_event(sys_ev), .syserr_target(sys_tgt), .therm_irq_take(therm_take),
    .syserr_irq_take(sys_take), .thread_enable(ten), .one_at_a_time_issue(serial),
    .dual_issue_en(dual), .ci_load_issue(ci_iss), .ci_load_done(ci_done),
    .flush_younger(flush), .dispatch_block(blk), .real_mode_limit_select(limit_sel),
    .tlb_fill_source(tlb), .partition_env_select(env), .part_dup(dup)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Bounds a hang: the whole sequence needs well under 300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  function automatic logic [63:0] b(input int unsigned n);
    return 64'h1 << n;
  endfunction

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request released by non-blocking update on the taking edge, so the next
  // task may raise it again at the following falling edge
  task automatic spr_wr(input dtc_sel_e s, input logic th, input logic [63:0] d);
    req = '{wr: 1'b1, rd: 1'b0, sel: s, thread: th, wdata: d};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
  endtask

  task automatic spr_rd(input dtc_sel_e s, input logic th, output logic [63:0] d);
    req = '{wr: 1'b0, rd: 1'b1, sel: s, thread: th, wdata: 64'h0};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk(64'(rvalid), 64'h1);
    d = rdata;
  endtask

  task automatic ev(input logic th, input logic sy, input logic [1:0] tg);
    therm_ev = th;
    sys_ev = sy;
    sys_tgt = tg;
    @(posedge clk);
    therm_ev <= 1'b0;
    sys_ev <= 1'b0;
    sys_tgt <= 2'h0;
    @(negedge clk);
  endtask

  task automatic ci(input logic [1:0] iss, input logic [1:0] dn);
    ci_iss = iss;
    ci_done = dn;
    @(posedge clk);
    ci_iss <= 2'h0;
    ci_done <= 2'h0;
    @(negedge clk);
  endtask

  task automatic t_reset();
    chk(64'(ten), 64'(DTC_RUN_EN_RESET));
    chk({62'h0, serial, dual}, 64'h1);
    spr_rd(DTC_SEL_CTRL, 1'b0, q);
    chk(q, b(DTC_CTRL_CT0) | b(DTC_CTRL_TE0));
    spr_rd(DTC_SEL_NONE, 1'b0, q);
    chk(q, 64'h0);
  endtask

  task automatic t_serial();
    spr_wr(DTC_SEL_IMPL, 1'b0, b(DTC_IMPL_SERIAL));
    chk({62'h0, serial, dual}, 64'h2);
    spr_rd(DTC_SEL_IMPL, 1'b1, q);
    chk(q, b(DTC_IMPL_SERIAL));
    spr_wr(DTC_SEL_IMPL, 1'b0, 64'h0);
    chk({62'h0, serial, dual}, 64'h1);
  endtask

  task automatic t_therm();
    // Wake on, master off: no take, but the suspended thread still rises
    spr_wr(DTC_SEL_IMPL, 1'b0, b(DTC_IMPL_THERM_WAKE));
    ev(1'b1, 1'b0, 2'h0);
    chk(64'(therm_take), 64'h0);
    chk(64'(ten), 64'h3);
    spr_wr(DTC_SEL_CTRL, 1'b1, b(DTC_CTRL_TE0));
    chk(64'(ten), 64'h1);
    spr_wr(DTC_SEL_IMPL, 1'b0, b(DTC_IMPL_THERM_MASTER));
    ev(1'b1, 1'b0, 2'h0);
    chk(64'(therm_take), 64'h1);
    chk(64'(ten), 64'h1);
    @(negedge clk);
    chk(64'(therm_take), 64'h0);
  endtask

  task automatic t_syserr();
    spr_wr(DTC_SEL_IMPL, 1'b0, b(DTC_IMPL_SYSERR_WAKE));
    spr_wr(DTC_SEL_CTRL, 1'b0, 64'h0);
    chk(64'(ten), 64'h0);
    ev(1'b0, 1'b1, 2'h1);
    chk(64'(sys_take), 64'h0);
    chk(64'(ten), 64'h1);
    spr_wr(DTC_SEL_IMPL, 1'b0, b(DTC_IMPL_SYSERR_WAKE) | b(DTC_IMPL_EXT_FAULT));
    ev(1'b0, 1'b1, 2'h3);
    chk(64'(sys_take), 64'h3);
    chk(64'(ten), 64'h3);
  endtask

  task automatic t_ctrl();
    priv[0] = '{hypervisor_bit: 1'b0, problem_bit: 1'b0};
    spr_wr(DTC_SEL_CTRL, 1'b0, 64'h0);
    chk(64'(ten), 64'h3);
    priv[0] = '{hypervisor_bit: 1'b1, problem_bit: 1'b1};
    spr_wr(DTC_SEL_CTRL, 1'b0, 64'h0);
    chk(64'(ten), 64'h3);
    priv[0] = '{hypervisor_bit: 1'b1, problem_bit: 1'b0};
    // Thread 1 tries to suspend thread 0 and pokes the read-only fields
    spr_wr(DTC_SEL_CTRL, 1'b1, b(DTC_CTRL_TE1) | b(DTC_CTRL_CT0) | b(DTC_CTRL_TH0));
    chk(64'(ten), 64'h3);
    spr_rd(DTC_SEL_CTRL, 1'b1, q);
    chk(q, b(DTC_CTRL_CT1) | b(DTC_CTRL_TE0) | b(DTC_CTRL_TE1)
      | b(DTC_CTRL_TH1));
    spr_wr(DTC_SEL_CTRL, 1'b1, b(DTC_CTRL_TE0));
    chk(64'(ten), 64'h1);
    spr_wr(DTC_SEL_CTRL, 1'b0, b(DTC_CTRL_TE0) | b(DTC_CTRL_TE1) | b(DTC_CTRL_RUN));
    chk(64'(ten), 64'h3);
    spr_rd(DTC_SEL_CTRL, 1'b0, q);
    chk(q, b(DTC_CTRL_CT0) | b(DTC_CTRL_TE0) | b(DTC_CTRL_TE1)
      | b(DTC_CTRL_TH0) | b(DTC_CTRL_RUN));
  endtask

  task automatic t_part();
    spr_wr(DTC_SEL_PART, 1'b0, 64'hffff_ffff_ffff_ffff);
    chk({57'h0, limit_sel, tlb, env}, 64'h7f);
    chk(64'(dup), 64'h7);
    spr_rd(DTC_SEL_PART, 1'b0, q);
    chk(q, 64'h3c00_0c0f);
    spr_rd(DTC_SEL_PART, 1'b1, q);
    chk(q, 64'h3c00_040c);
    spr_wr(DTC_SEL_PART, 1'b1, 64'h0);
    chk({57'h0, limit_sel, tlb, env}, 64'h0);
    chk(64'(dup), 64'h7);
    spr_rd(DTC_SEL_PART, 1'b0, q);
    chk(q, 64'h0803);
  endtask

  task automatic t_load();
    spr_wr(DTC_SEL_IMPL, 1'b0, 64'h0);
    ci(2'h1, 2'h0);
    chk({60'h0, flush, blk}, 64'h0);
    spr_wr(DTC_SEL_IMPL, 1'b0, b(DTC_IMPL_PREC_MCHK));
    ci(2'h2, 2'h0);
    chk({60'h0, flush, blk}, 64'ha);
    ci(2'h2, 2'h0);
    chk({60'h0, flush, blk}, 64'h2);
    ci(2'h0, 2'h2);
    chk({60'h0, flush, blk}, 64'h0);
    ci(2'h1, 2'h0);
    chk({60'h0, flush, blk}, 64'h5);
    ci(2'h0, 2'h1);
    chk({60'h0, flush, blk}, 64'h0);
  endtask

  initial begin
    reset = 1'b1;
    req = '0;
    priv = {2{dtc_priv_s'{hypervisor_bit: 1'b1, problem_bit: 1'b0}}};
    therm_ev = 1'b0;
    sys_ev = 1'b0;
    sys_tgt = 2'h0;
    ci_iss = 2'h0;
    ci_done = 2'h0;
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_reset();
    t_serial();
    t_therm();
    t_syserr();
    t_ctrl();
    t_part();
    t_load();
    report_and_stop();
  end
endmodule
